//--- shared/apdc_pkg.sv
package apdc_pkg;
	// Command codes
	localparam logic [7:0] CMD_ALERT2_SETUP = 8'hd6;
	localparam logic [7:0] CMD_SETTINGS = 8'hd8;
	localparam logic [7:0] CMD_RESTART = 8'hd9;
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	// Reset values
	localparam logic [15:0] ALERT2_RESET = 16'h8000;
	localparam logic [7:0] SETTINGS_RESET = 8'h00;
	// Writable bit masks, reserved bits excluded
	localparam logic [15:0] ALERT2_WMASK = 16'hfffb;
	localparam logic [7:0] SETTINGS_WMASK = 8'hf0;
	// Alert setup fields
	localparam int A2_SWITCH_FAULT_EN = 15;
	localparam int A2_SRC_HI = 9;
	localparam int A2_SRC_LO = 4;
	localparam int A2_POLARITY = 3;
	localparam int A2_GPO_SEL = 1;
	localparam int A2_GPO_LEVEL = 0;
	// Settings fields
	localparam int ST_FILTER_LEN = 7;
	localparam int ST_FOLDBACK_OFF = 6;
	localparam int ST_ON_OFF_ACCEPT = 5;
	localparam int ST_THRESH_DIR = 4;
	// Flag vector width: bits 15..4 of the setup word
	localparam int FLAG_W = 12;
	typedef enum logic [1:0] {
		APDC_ACK,
		APDC_NACK
	} apdc_resp_type;
endpackage : apdc_pkg

//--- rtl/apdc_pin_drive.sv
`timescale 1ns/1ps
module apdc_pin_drive (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Configuration
	input wire logic gpo_sel_in,
	input wire logic gpo_level_in,
	input wire logic polarity_in,
	input wire logic alert_req_in,
	// Pin
	output logic pin_out
);
	typedef struct packed {
		logic pin;
	} apdc_pd_state_type;
	apdc_pd_state_type state;
	apdc_pd_state_type next_state;

	always_comb begin
		next_state = state;
		if (gpo_sel_in) begin
			next_state.pin = gpo_level_in;
		end else begin
			// Idle level is the inverse of the active level
			next_state.pin = polarity_in ? alert_req_in : ~alert_req_in;
		end
	end

	// Reset level high: default polarity is active low, so no false alert
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= '{pin: 1'b1};
		end else begin
			state <= next_state;
		end
	end

	assign pin_out = state.pin;
endmodule : apdc_pin_drive

//--- rtl/apdc_config.sv
`timescale 1ns/1ps
module apdc_config (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Decoded command port from the bus engine
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [1:0] cmd_len_in,
	input wire logic [15:0] cmd_wdata_in,
	// Command answer
	output logic resp_valid_out,
	output logic resp_nack_out,
	output logic [15:0] resp_rdata_out,
	// Status flags, bits 15..4 of the setup word order
	input wire logic [11:0] flags_in,
	input wire logic operation_done_in,
	// Device controls
	output logic filter_short_out,
	output logic foldback_off_out,
	output logic threshold_over_out,
	output logic operation_strobe_out,
	output logic restart_strobe_out,
	// Second alert pin
	output logic second_alert_output_pin_out
);
	typedef struct packed {
		logic [15:0] alert2;
		logic [7:0] settings;
		logic resp_valid;
		logic resp_nack;
		logic [15:0] rdata;
		logic op_strobe;
		logic rs_strobe;
		logic alert_req;
	} apdc_state_type;
	apdc_state_type state;
	apdc_state_type next_state;
	logic [11:0] flags_q1;
	logic [11:0] flags_q2;

	// Readback with reserved bits masked
	function automatic logic [15:0] apdc_read(input logic [7:0] code, input logic [15:0] a2,
			input logic [7:0] st);
		apdc_read = 16'h0000;
		case (code)
			apdc_pkg::CMD_ALERT2_SETUP: apdc_read = a2 & apdc_pkg::ALERT2_WMASK;
			apdc_pkg::CMD_SETTINGS: apdc_read = {8'h00, st & apdc_pkg::SETTINGS_WMASK};
			default: apdc_read = 16'h0000;
		endcase
	endfunction : apdc_read

	// Flags come from analog comparators outside this clock
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flags_q1 <= 12'h000;
			flags_q2 <= 12'h000;
		end else begin
			flags_q1 <= flags_in;
			flags_q2 <= flags_q1;
		end
	end

	always_comb begin
		logic [11:0] enables;
		enables = 12'h000;
		next_state = state;
		next_state.resp_valid = 1'b0;
		next_state.resp_nack = 1'b0;
		next_state.op_strobe = 1'b0;
		next_state.rs_strobe = 1'b0;
		if (cmd_valid_in) begin
			next_state.resp_valid = 1'b1;
			case (cmd_code_in)
				apdc_pkg::CMD_ALERT2_SETUP: begin
					if (cmd_write_in && cmd_len_in == 2'd2) begin
						next_state.alert2 = cmd_wdata_in & apdc_pkg::ALERT2_WMASK;
					end else if (cmd_write_in) begin
						next_state.resp_nack = 1'b1;
					end
				end
				apdc_pkg::CMD_SETTINGS: begin
					// Byte-sized writes only; reads of any length are accepted
					if (cmd_write_in && cmd_len_in == 2'd1) begin
						next_state.settings = cmd_wdata_in[7:0] & apdc_pkg::SETTINGS_WMASK;
					end else if (cmd_write_in) begin
						next_state.resp_nack = 1'b1;
					end
				end
				apdc_pkg::CMD_RESTART: begin
					// Send-byte: write with no data bytes
					if (cmd_write_in && cmd_len_in == 2'd0) begin
						next_state.rs_strobe = 1'b1;
					end else begin
						next_state.resp_nack = 1'b1;
					end
				end
				apdc_pkg::CMD_OPERATION: begin
					// Guards against a card turning itself off by accident
					if (state.settings[apdc_pkg::ST_ON_OFF_ACCEPT] && cmd_write_in) begin
						next_state.op_strobe = 1'b1;
					end else begin
						next_state.resp_nack = 1'b1;
					end
				end
				default: next_state.resp_nack = 1'b1;
			endcase
			if (!cmd_write_in) begin
				next_state.rdata = apdc_read(cmd_code_in, state.alert2, state.settings);
			end
		end
		// Setup bits 15..4 gate the synchronised flags
		enables = state.alert2[15:4];
		next_state.alert_req = |(enables & flags_q2);
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= '{alert2: apdc_pkg::ALERT2_RESET,
				settings: apdc_pkg::SETTINGS_RESET,
				rdata: 16'h0000, default: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	apdc_pin_drive u_pin (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.gpo_sel_in(state.alert2[apdc_pkg::A2_GPO_SEL]),
		.gpo_level_in(state.alert2[apdc_pkg::A2_GPO_LEVEL]),
		.polarity_in(state.alert2[apdc_pkg::A2_POLARITY]),
		.alert_req_in(state.alert_req),
		.pin_out(second_alert_output_pin_out)
	);

	assign resp_valid_out = state.resp_valid;
	assign resp_nack_out = state.resp_nack;
	assign resp_rdata_out = state.rdata;
	assign filter_short_out = state.settings[apdc_pkg::ST_FILTER_LEN];
	assign foldback_off_out = state.settings[apdc_pkg::ST_FOLDBACK_OFF];
	assign threshold_over_out = state.settings[apdc_pkg::ST_THRESH_DIR];
	assign operation_strobe_out = state.op_strobe;
	assign restart_strobe_out = state.rs_strobe;
endmodule : apdc_config

//--- tb/apdc_config_monitor.sv
`timescale 1ns/1ps
module apdc_config_monitor (
	// Clock, reset and command port
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [1:0] cmd_len_in,
	input wire logic [15:0] cmd_wdata_in,
	// Answers and controls
	input wire logic resp_valid_out,
	input wire logic resp_nack_out,
	input wire logic [15:0] resp_rdata_out,
	input wire logic filter_short_out,
	input wire logic foldback_off_out,
	input wire logic threshold_over_out,
	input wire logic operation_strobe_out,
	input wire logic restart_strobe_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire wr = cmd_valid_in && cmd_write_in;
	a_answer_one: assert property (resp_valid_out == $past(cmd_valid_in))
		else $error("answer timing");
	a_op_read: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == 8'h01
		|=> resp_nack_out) else $error("op read taken");
	a_op_ack: assert property (operation_strobe_out |-> !resp_nack_out
		&& $past(wr && cmd_code_in == 8'h01)) else $error("bad op strobe");
	a_restart_ok: assert property (wr && cmd_code_in == 8'hd9 && cmd_len_in == 2'h0
		|=> restart_strobe_out && !resp_nack_out) else $error("restart lost");
	a_byte_len: assert property (wr && cmd_code_in == 8'hd8
		|=> resp_nack_out == $past(cmd_len_in != 2'h1)) else $error("length check");
	a_cfg_write: assert property (wr && cmd_code_in == 8'hd8 && cmd_len_in == 2'h1
		|=> {filter_short_out, foldback_off_out, threshold_over_out}
		== {$past(cmd_wdata_in[7:6]), $past(cmd_wdata_in[4])}) else $error("settings out");
	a_cfg_hold: assert property (!$past(wr && cmd_code_in == 8'hd8)
		|-> $stable({filter_short_out, foldback_off_out, threshold_over_out}))
		else $error("settings drift");
	a_rdata_hold: assert property (!$past(cmd_valid_in && !cmd_write_in)
		|-> $stable(resp_rdata_out)) else $error("read data drift");
endmodule : apdc_config_monitor
bind apdc_config apdc_config_monitor apdc_config_monitor_i (.*);

//--- tb/apdc_host.sv
`timescale 1ns/1ps
module apdc_host (
	// Clock
	input wire logic clk_in,
	// Command port
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic [1:0] cmd_len_out,
	output logic [15:0] cmd_wdata_out
);
	initial {cmd_valid_out, cmd_write_out, cmd_code_out, cmd_len_out, cmd_wdata_out} = '0;
	// Byte, word or send-byte sized, one per call
	task automatic cmd(input logic w, input logic [7:0] c, input logic [1:0] n,
			input logic [15:0] d);
		@(posedge clk_in);
		#1 {cmd_valid_out, cmd_write_out, cmd_code_out, cmd_len_out, cmd_wdata_out} = {1'b1, w, c, n, d};
		@(posedge clk_in);
		#1 cmd_valid_out = 1'b0;
		// Stale data never looks valid
		cmd_wdata_out = ~d;
	endtask : cmd
endmodule : apdc_host

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_in, rst_b_in, cmd_valid_in, cmd_write_in, resp_valid_out, resp_nack_out;
	logic operation_done_in, filter_short_out, foldback_off_out, threshold_over_out;
	logic operation_strobe_out, restart_strobe_out, second_alert_output_pin_out;
	logic [7:0] cmd_code_in;
	logic [1:0] cmd_len_in;
	logic [15:0] cmd_wdata_in, resp_rdata_out;
	logic [11:0] flags_in;
	int mismatches = 0;
	int checks = 0;
	apdc_host apdc_host_i (.clk_in(clk_in), .cmd_valid_out(cmd_valid_in),
		.cmd_write_out(cmd_write_in), .cmd_code_out(cmd_code_in),
		.cmd_len_out(cmd_len_in), .cmd_wdata_out(cmd_wdata_in));
	apdc_config apdc_config_i (.*);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] c, input logic [1:0] n,
			input logic [15:0] d, input logic nack, input logic [15:0] exp);
		apdc_host_i.cmd(w, c, n, d);
		chk({resp_valid_out, resp_nack_out}, {1'b1, nack});
		if (!w) chk(resp_rdata_out, exp);
	endtask : xfer
	task automatic pin_is(input logic exp);
		repeat (5) @(posedge clk_in);
		#1 chk(second_alert_output_pin_out, exp);
	endtask : pin_is
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial begin
		rst_b_in = 1'b0;
		operation_done_in = 1'b0;
		flags_in = 12'h000;
		repeat (10) @(posedge clk_in);
		#1 rst_b_in = 1'b1;
		xfer(1'b0, 8'hd6, 2'h2, 16'h0, 1'b0, 16'h8000);
		xfer(1'b0, 8'hd8, 2'h1, 16'h0, 1'b0, 16'h0000);
		flags_in = 12'h800;
		pin_is(1'b0);
		flags_in = 12'h000;
		xfer(1'b1, 8'h01, 2'h1, 16'h0080, 1'b1, 16'h0);
		chk(operation_strobe_out, 1'b0);
		xfer(1'b1, 8'hd8, 2'h2, 16'h00ff, 1'b1, 16'h0);
		xfer(1'b1, 8'hd6, 2'h1, 16'h00ff, 1'b1, 16'h0);
		xfer(1'b0, 8'hd6, 2'h2, 16'h0, 1'b0, 16'h8000);
		xfer(1'b0, 8'hd9, 2'h0, 16'h0, 1'b1, 16'h0000);
		xfer(1'b1, 8'hd8, 2'h1, 16'h00ff, 1'b0, 16'h0);
		chk({filter_short_out, foldback_off_out, threshold_over_out}, 16'h7);
		xfer(1'b0, 8'hd8, 2'h1, 16'h0, 1'b0, 16'h00f0);
		xfer(1'b1, 8'h01, 2'h1, 16'h0080, 1'b0, 16'h0);
		chk(operation_strobe_out, 1'b1);
		xfer(1'b1, 8'hd9, 2'h0, 16'h0, 1'b0, 16'h0);
		chk(restart_strobe_out, 1'b1);
		xfer(1'b1, 8'hd9, 2'h1, 16'h0, 1'b1, 16'h0);
		chk(restart_strobe_out, 1'b0);
		xfer(1'b1, 8'hd8, 2'h1, 16'h0020, 1'b0, 16'h0);
		chk({filter_short_out, foldback_off_out, threshold_over_out}, 16'h0);
		xfer(1'b1, 8'hd6, 2'h2, 16'hffff, 1'b0, 16'h0);
		xfer(1'b0, 8'hd6, 2'h2, 16'h0, 1'b0, 16'hfffb);
		// One source enabled, active-high alert
		for (int i = 0; i < 6; i++) begin
			xfer(1'b1, 8'hd6, 2'h2, (16'h0010 << i) | 16'h0008, 1'b0, 16'h0);
			flags_in = 12'h001 << i;
			pin_is(1'b1);
			flags_in = ~(12'h001 << i);
			pin_is(1'b0);
		end
		xfer(1'b1, 8'hd6, 2'h2, 16'h0003, 1'b0, 16'h0);
		pin_is(1'b1);
		xfer(1'b1, 8'hd6, 2'h2, 16'h0002, 1'b0, 16'h0);
		pin_is(1'b0);
		end_sim();
	end
endmodule : testbench
